// file: pwl_defs.svh
`ifndef PWL_DEFS_SVH
`define PWL_DEFS_SVH
// Register indexes; byte address = 4 * index
`define PWL_IDX_LV_CTRL      10'h2f1
`define PWL_IDX_WAKE_CTRL    10'h2f2
`define PWL_IDX_WAKE_TRIM    10'h2f3
`define PWL_IDX_RATE_HI      10'h2f4
`define PWL_IDX_RATE_LO      10'h2f5
`define PWL_IDX_RAW_STATUS   10'h2f8
// Field positions
`define PWL_LV_STATUS_BIT    2
`define PWL_LV_IRQEN_BIT     1
`define PWL_LV_FLAG_BIT      0
`define PWL_CLKSEL_BIT       7
`define PWL_WAVE_BIT         4
`define PWL_PINEN_BIT        3
`define PWL_FEAT_BIT         2
`define PWL_WIRQEN_BIT       1
`define PWL_WFLAG_BIT        0
`define PWL_TRIM_LSB         2
// Reset values
`define PWL_CTRL_RST         8'h00
`define PWL_RATE_RST         16'h0000
// Timing: oscillator tick 0.1 ms, expressed in ns
`define PWL_OSC_TICK_NS      100000
`define PWL_CLK_NS           100
`define PWL_NOMINAL_TICK     (`PWL_OSC_TICK_NS / `PWL_CLK_NS)
`endif

// file: pwl_pkg.sv
package pwl_pkg;
  typedef struct packed {
    logic       clk_sel;
    logic       wave_sel;
    logic       pin_en;
    logic       feat_en;
    logic       irq_en;
  } pwl_wake_cfg_t;
  typedef struct packed {
    logic       lv_irq;
    logic       wake_irq;
    logic       wake_pin;
    logic       wake_pin_oe;
  } pwl_out_t;
endpackage

// file: pwl_osc_tick.sv
`timescale 1ns/1ns
`include "pwl_defs.svh"
// Slow oscillator model: a tick every 0.1 ms, trimmed by the 6-bit trim value
module pwl_osc_tick #(
  parameter int NOMINAL = `PWL_NOMINAL_TICK
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic [5:0] i_trim,
  output logic            o_tick
);
  localparam int CW = 16;
  // A 16-bit counter must hold the lengthened tick, and the trim step must not vanish
  if (NOMINAL < 64 || NOMINAL > 43000) begin : g_bad_nominal
    $error("NOMINAL out of range");
  end
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          tick_r;
  logic          tick_nxt;
  logic [CW-1:0] limit;
  // Top bit lengthens; lower bits shorten with halving weight
  function automatic logic [CW-1:0] trim_len(input logic [5:0] t);
    logic [CW-1:0] base;
    logic [CW-1:0] step;
    base = CW'(NOMINAL);
    step = base >> 6;
    // Coarse steps, so that even a short tick shows every trim bit
    trim_len = base + (t[5] ? (step << 5) : '0) - ({11'h000, t[4:0]} * step);
  endfunction
  always_comb begin
    limit    = trim_len(i_trim);
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (!i_run) begin
      cnt_nxt = '0;
    end else if (cnt_r >= limit - 16'h0001) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign o_tick = tick_r;
endmodule // pwl_osc_tick

// file: pwl_top.sv
// What this block does
// - Low-voltage status at bit 2 is read-only; writes ignored.
// - Status reads 1 only when below assert level in full performance mode.
// - Low-voltage irq when change flag set and enable bit 1 high.
// - Change flag bit 0 sets on status change; write 1 clears.
// - Reduced power entry sets the change flag if status was 1.
// - Bit 7 selects timer clock: 0 slow oscillator, 1 bus clock.
// - Clock select writable only while feature enable is 0 before write and the write leaves it 0.
// - Bit 4: 1 gives clock of twice period, 0 gives short pulse.
// - Pin driven only when pin enable bit 3 and feature enable set.
// - Feature enable bit 2 starts timer; clearing stops it.
// - Wake irq when timeout flag set and enable bit 1 high.
// - Timeout flag bit 0 sets each elapsed period.
// - Write 1 clears timeout flag; clearing wins over a coincident set.
// - Six-bit trim held in bits 7 to 2; low bits read zero.
// - Trim: top bit lengthens, lower bits shorten with decreasing weight.
// - Trim resets to zero or to an external factory value.
// - Period is 2*(rate+1) ticks of 0.1 ms or bus clock.
// - Rate value writable only while feature enable is 0.
// - Detection works in full performance mode only.
`timescale 1ns/1ns
`include "pwl_defs.svh"
module pwl_top
  import pwl_pkg::*;
#(
  parameter int OSC_TICK = `PWL_NOMINAL_TICK
) (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic [11:0] i_address,
  input  wire logic       i_read,
  input  wire logic       i_write,
  input  wire logic [31:0] i_writedata,
  input  wire logic [3:0] i_byteenable,
  output logic [31:0]     o_readdata,
  output logic            o_waitrequest,
  input  wire logic       i_lowvolt_below,
  input  wire logic       i_reduced_power_mode,
  input  wire logic       i_trim_preset_valid,
  input  wire logic [5:0] i_trim_preset,
  output logic            o_lowvolt_irq,
  output logic            o_wake_irq,
  output logic            o_wake_pin,
  output logic            o_wake_pin_oe
);
  import pwl_pkg::*;
  // Tick counter is 16 bits wide; trim steps vanish below 64
  if (OSC_TICK < 64 || OSC_TICK > 43000) begin : g_bad_tick
    $error("OSC_TICK out of range");
  end
  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];
  logic [2:0] lv_sync_r;
  logic [2:0] rpm_sync_r;
  logic       lv_in_r;
  logic       lv_in_nxt;
  logic       rpm_r;
  logic       rpm_nxt;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      lv_sync_r  <= 3'h0;
      rpm_sync_r <= 3'h0;
    end else begin
      lv_sync_r  <= {lv_sync_r[1:0], i_lowvolt_below};
      rpm_sync_r <= {rpm_sync_r[1:0], i_reduced_power_mode};
    end
  end
  always_comb begin
    lv_in_nxt = (lv_sync_r[2] == lv_sync_r[1]) ? lv_sync_r[1] : lv_in_r;
    rpm_nxt   = (rpm_sync_r[2] == rpm_sync_r[1]) ? rpm_sync_r[1] : rpm_r;
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic          lv_stat_r, lv_stat_nxt;
  logic          lv_flag_r, lv_flag_nxt;
  logic          lv_ien_r, lv_ien_nxt;
  pwl_wake_cfg_t cfg_r, cfg_nxt;
  logic          w_flag_r, w_flag_nxt;
  logic [5:0]    trim_r, trim_nxt;
  logic [15:0]   rate_r, rate_nxt;
  logic          trim_load_r;
  logic [16:0]   per_cnt_r, per_cnt_nxt;
  logic          wave_r, wave_nxt;
  logic          pulse_r, pulse_nxt;
  logic          req_done_r, req_done_nxt;
  logic [31:0]   rdata_r, rdata_nxt;
  logic          waitreq_r, waitreq_nxt;
  pwl_out_t      out_r, out_nxt;
  logic          osc_tick;
  logic          tick;
  logic          timeout;
  logic [9:0]    idx;
  logic          wr, rd;
  logic [7:0]    wb;
  assign idx = i_address[11:2];
  // Writes commit on the edge that ends the wait state, as the master expects
  assign wr  = i_write && req_done_r;
  assign rd  = i_read && !req_done_r;
  assign wb  = i_byteenable[0] ? i_writedata[7:0] : 8'h00;
  pwl_osc_tick #(
    .NOMINAL (OSC_TICK)
  ) u_osc (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_run   (cfg_r.feat_en && !cfg_r.clk_sel),
    .i_trim  (trim_r),
    .o_tick  (osc_tick)
  );
  assign tick    = cfg_r.clk_sel ? 1'b1 : osc_tick;
  assign timeout = cfg_r.feat_en && tick && (per_cnt_r == {rate_r, 1'b1});
  always_comb begin
    lv_stat_nxt  = lv_in_nxt && !rpm_nxt;
    lv_flag_nxt  = lv_flag_r;
    if (wr && idx == `PWL_IDX_LV_CTRL && wb[`PWL_LV_FLAG_BIT]) begin
      lv_flag_nxt = 1'b0;
    end
    if (lv_stat_nxt != lv_stat_r) begin
      lv_flag_nxt = 1'b1;
    end
    lv_ien_nxt = lv_ien_r;
    cfg_nxt    = cfg_r;
    w_flag_nxt = w_flag_r;
    trim_nxt   = trim_r;
    rate_nxt   = rate_r;
    if (!trim_load_r && i_trim_preset_valid) begin
      trim_nxt = i_trim_preset;
    end
    if (timeout) begin
      w_flag_nxt = 1'b1;
    end
    if (wr && i_byteenable[0]) begin
      if (idx == `PWL_IDX_LV_CTRL) begin
        lv_ien_nxt = wb[`PWL_LV_IRQEN_BIT];
      end else if (idx == `PWL_IDX_WAKE_CTRL) begin
        if (!cfg_r.feat_en && !wb[`PWL_FEAT_BIT]) begin
          cfg_nxt.clk_sel = wb[`PWL_CLKSEL_BIT];
        end
        cfg_nxt.wave_sel = wb[`PWL_WAVE_BIT];
        cfg_nxt.pin_en   = wb[`PWL_PINEN_BIT];
        cfg_nxt.feat_en  = wb[`PWL_FEAT_BIT];
        cfg_nxt.irq_en   = wb[`PWL_WIRQEN_BIT];
        if (wb[`PWL_WFLAG_BIT]) begin
          w_flag_nxt = 1'b0;
        end
      end else if (idx == `PWL_IDX_WAKE_TRIM) begin
        trim_nxt = wb[7:`PWL_TRIM_LSB];
      end else if (idx == `PWL_IDX_RATE_HI && !cfg_r.feat_en) begin
        rate_nxt[15:8] = wb;
      end else if (idx == `PWL_IDX_RATE_LO && !cfg_r.feat_en) begin
        rate_nxt[7:0] = wb;
      end
    end
  end
  // ----------------------------------------------------------------
  // Period counter and pin waveform
  // ----------------------------------------------------------------
  always_comb begin
    per_cnt_nxt = per_cnt_r;
    wave_nxt    = wave_r;
    pulse_nxt   = pulse_r;
    if (!cfg_r.feat_en) begin
      per_cnt_nxt = 17'h00000;
      wave_nxt    = 1'b0;
      pulse_nxt   = 1'b0;
    end else if (tick) begin
      pulse_nxt = 1'b0;
      if (timeout) begin
        per_cnt_nxt = 17'h00000;
        wave_nxt    = !wave_r;
        pulse_nxt   = 1'b1; // lasts one tick, half the minimum period
      end else begin
        per_cnt_nxt = per_cnt_r + 17'h00001;
      end
    end
    out_nxt.lv_irq      = lv_flag_nxt && lv_ien_nxt;
    out_nxt.wake_irq    = w_flag_nxt && cfg_nxt.irq_en;
    out_nxt.wake_pin_oe = cfg_nxt.pin_en && cfg_nxt.feat_en;
    out_nxt.wake_pin    = out_nxt.wake_pin_oe &&
                          (cfg_nxt.wave_sel ? wave_nxt : pulse_nxt);
  end
  // ----------------------------------------------------------------
  // Bus answer: one wait cycle, then done
  // ----------------------------------------------------------------
  always_comb begin
    req_done_nxt = (i_read || i_write) && !req_done_r;
    waitreq_nxt  = !req_done_nxt;
    rdata_nxt    = 32'h00000000;
    if (rd) begin
      if (idx == `PWL_IDX_LV_CTRL) begin
        rdata_nxt[7:0] = {5'h00, lv_stat_r, lv_ien_r, lv_flag_r};
      end else if (idx == `PWL_IDX_WAKE_CTRL) begin
        rdata_nxt[7:0] = {cfg_r.clk_sel, 2'h0, cfg_r.wave_sel, cfg_r.pin_en,
                          cfg_r.feat_en, cfg_r.irq_en, w_flag_r};
      end else if (idx == `PWL_IDX_WAKE_TRIM) begin
        rdata_nxt[7:0] = {trim_r, 2'h0};
      end else if (idx == `PWL_IDX_RATE_HI) begin
        rdata_nxt[7:0] = rate_r[15:8];
      end else if (idx == `PWL_IDX_RATE_LO) begin
        rdata_nxt[7:0] = rate_r[7:0];
      end else if (idx == `PWL_IDX_RAW_STATUS) begin
        rdata_nxt[7:0] = {6'h00, rpm_r, lv_in_r};
      end
    end else if (req_done_r) begin
      rdata_nxt = rdata_r;
    end
  end
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      lv_in_r     <= 1'b0;
      rpm_r       <= 1'b0;
      lv_stat_r   <= 1'b0;
      lv_flag_r   <= 1'b0;
      lv_ien_r    <= 1'b0;
      cfg_r       <= '0;
      w_flag_r    <= 1'b0;
      trim_r      <= 6'h00;
      trim_load_r <= 1'b0;
      rate_r      <= `PWL_RATE_RST;
      per_cnt_r   <= 17'h00000;
      wave_r      <= 1'b0;
      pulse_r     <= 1'b0;
      req_done_r  <= 1'b0;
      waitreq_r   <= 1'b1;
      rdata_r     <= 32'h00000000;
      out_r       <= '0;
    end else begin
      lv_in_r     <= lv_in_nxt;
      rpm_r       <= rpm_nxt;
      lv_stat_r   <= lv_stat_nxt;
      lv_flag_r   <= lv_flag_nxt;
      lv_ien_r    <= lv_ien_nxt;
      cfg_r       <= cfg_nxt;
      w_flag_r    <= w_flag_nxt;
      trim_r      <= trim_nxt;
      trim_load_r <= 1'b1;
      rate_r      <= rate_nxt;
      per_cnt_r   <= per_cnt_nxt;
      wave_r      <= wave_nxt;
      pulse_r     <= pulse_nxt;
      req_done_r  <= req_done_nxt;
      waitreq_r   <= waitreq_nxt;
      rdata_r     <= rdata_nxt;
      out_r       <= out_nxt;
    end
  end
  assign o_readdata    = rdata_r;
  assign o_waitrequest = waitreq_r;
  assign o_lowvolt_irq = out_r.lv_irq;
  assign o_wake_irq    = out_r.wake_irq;
  assign o_wake_pin    = out_r.wake_pin;
  assign o_wake_pin_oe = out_r.wake_pin_oe;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);
  lv_irq_and_a: assert property (o_lowvolt_irq == (lv_flag_r && lv_ien_r))
    else $error("lowvolt irq mismatch");
  wake_irq_and_a: assert property (o_wake_irq == (w_flag_r && cfg_r.irq_en))
    else $error("wake irq mismatch");
  lv_flag_set_a: assert property (lv_stat_r != $past(lv_stat_r) |-> lv_flag_r)
    else $error("lowvolt flag not set");
  lv_rpm_zero_a: assert property (rpm_r |-> !lv_stat_r)
    else $error("status high in reduced power");
  clk_sel_lock_a: assert property (cfg_r.feat_en |=> $stable(cfg_r.clk_sel))
    else $error("clock select changed while enabled");
  clk_sel_same_a: assert property (
    wr && idx == `PWL_IDX_WAKE_CTRL && wb[`PWL_FEAT_BIT] |=> $stable(cfg_r.clk_sel))
    else $error("clock select changed by enabling write");
  rate_lock_a: assert property (cfg_r.feat_en |=> $stable(rate_r))
    else $error("rate changed while enabled");
  wake_flag_a: assert property (
    timeout && !(wr && idx == `PWL_IDX_WAKE_CTRL && wb[0]) |=> w_flag_r)
    else $error("timeout flag not set");
  clear_wins_a: assert property (
    wr && i_byteenable[0] && idx == `PWL_IDX_WAKE_CTRL && wb[0] |=> !w_flag_r)
    else $error("clear lost to set");
  pin_gate_a: assert property (o_wake_pin_oe == (cfg_r.pin_en && cfg_r.feat_en))
    else $error("pin driven while disabled");
  pin_quiet_a: assert property (o_wake_pin |-> o_wake_pin_oe)
    else $error("pin active while not driven");
  bus_period_a: assert property (
    (cfg_r.feat_en && cfg_r.clk_sel && rate_r == 16'h0000 && timeout) ##1 cfg_r.feat_en [*2]
    |-> timeout)
    else $error("bus clock period wrong");
  timeout_cv: cover property (timeout);
  lv_change_cv: cover property (lv_flag_r && lv_ien_r);
  pin_wave_cv: cover property (o_wake_pin_oe && o_wake_pin);
  clear_race_cv: cover property (timeout && wr && idx == `PWL_IDX_WAKE_CTRL && wb[0]);
  lv_rpm_cv: cover property (rpm_r && lv_flag_r);
endmodule // pwl_top

// file: pwl_top_tb.sv
`timescale 1ns/1ns
`include "pwl_defs.svh"
module pwl_top_tb;
  import pwl_pkg::*;
  // ------------------------------------------------------------
  // Signals and table
  // ------------------------------------------------------------
  typedef struct {
    logic [9:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } pwl_row_t;
  logic        i_clk, i_rstn, i_read, i_write;
  logic [11:0] i_address;
  logic [31:0] i_writedata, o_readdata;
  logic [3:0]  i_byteenable;
  logic        o_waitrequest, i_lowvolt_below, i_reduced_power_mode;
  logic        i_trim_preset_valid, o_lowvolt_irq, o_wake_irq, o_wake_pin, o_wake_pin_oe;
  logic [5:0]  i_trim_preset;
  int          num_errors, n_checks, per, hi, p0, p1, p2, p3;
  pwl_row_t    rows [8] = '{
    '{10'h2f3, 8'hff, 8'hfc},
    '{10'h2f1, 8'h06, 8'h02},
    '{10'h2f0, 8'hff, 8'h00},
    '{10'h2f2, 8'h9a, 8'h9a},
    '{10'h2f2, 8'h00, 8'h00},
    '{10'h2f5, 8'h03, 8'h03},
    '{10'h2f4, 8'h00, 8'h00},
    '{10'h2f1, 8'h00, 8'h00}};

  pwl_top #(.OSC_TICK(64)) pwl_top_i (.i_clk, .i_rstn, .i_address, .i_read, .i_write,
    .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest, .i_lowvolt_below,
    .i_reduced_power_mode, .i_trim_preset_valid, .i_trim_preset, .o_lowvolt_irq,
    .o_wake_irq, .o_wake_pin, .o_wake_pin_oe);

  always #50 i_clk = ~i_clk;

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Avalon request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    i_address   <= {idx, 2'b00};
    i_write     <= wr;
    i_read      <= !wr;
    i_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'b0 && n < 20);
    if (o_waitrequest !== 1'b0) begin
      num_errors++;
      stop_test();
    end
    q = o_readdata[7:0];
    i_write <= 1'b0;
    i_read  <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk("readdata", q, exp);
  endtask

  // Bounded wait for the pin level, counting the cycles spent
  task automatic wait_lvl(input logic v, inout int n, inout int c);
    while (o_wake_pin !== v && n < 3000) begin
      @(posedge i_clk);
      n++;
      c++;
    end
  endtask

  task automatic meas(output int p, output int h);
    int n, d;
    n = 0;
    d = 0;
    h = 0;
    wait_lvl(1'b0, n, d);
    wait_lvl(1'b1, n, d);
    wait_lvl(1'b0, n, h);
    p = h;
    wait_lvl(1'b1, n, p);
    if (n >= 3000) begin
      num_errors++;
      stop_test();
    end
  endtask

  // First period after a trim change may be mixed, so it is dropped
  task automatic trimp(input logic [7:0] d, output int p);
    int h;
    wr(10'h2f3, d);
    meas(p, h);
    meas(p, h);
  endtask

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    i_clk = 0; i_rstn = 0; i_read = 0; i_write = 0; i_address = 0; i_writedata = 0;
    i_byteenable = 4'hf; i_lowvolt_below = 0; i_reduced_power_mode = 0;
    i_trim_preset_valid = 1; i_trim_preset = 6'h2a; num_errors = 0; n_checks = 0;
    repeat (3) @(posedge i_clk);
    chk("waitrequest", o_waitrequest, 1);
    chk("outputs", {o_lowvolt_irq, o_wake_irq, o_wake_pin, o_wake_pin_oe}, 0);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    rdc(10'h2f3, 8'ha8);
    rdc(10'h2f2, 8'h00);
    foreach (rows[k]) begin
      wr(rows[k].idx, rows[k].wd);
      rdc(rows[k].idx, rows[k].exp);
    end
    wr(10'h2f2, 8'h80);
    wr(10'h2f2, 8'h9e);
    repeat (2) @(posedge i_clk);
    chk("pin_oe", o_wake_pin_oe, 1);
    meas(per, hi);
    chk("half_period", hi, 8);
    chk("clock_period", per, 16);
    meas(per, hi);
    chk("clock_period", per, 16);
    chk("wake_irq", o_wake_irq, 1);
    rdc(10'h2f2, 8'h9f);
    wr(10'h2f2, 8'h9c);
    repeat (2) @(posedge i_clk);
    chk("wake_irq", o_wake_irq, 0);
    wr(10'h2f5, 8'h07);
    wr(10'h2f2, 8'h80);
    repeat (2) @(posedge i_clk);
    chk("pin_oe", {o_wake_pin_oe, o_wake_pin}, 0);
    rdc(10'h2f5, 8'h03);
    rdc(10'h2f2, 8'h81);
    wr(10'h2f2, 8'h01);
    rdc(10'h2f2, 8'h00);
    wr(10'h2f2, 8'h84);
    wr(10'h2f2, 8'h84);
    rdc(10'h2f2, 8'h04);
    wr(10'h2f5, 8'h00);
    wr(10'h2f2, 8'h00);
    wr(10'h2f5, 8'h00);
    wr(10'h2f2, 8'h0c);
    trimp(8'h00, p0);
    meas(per, hi);
    chk("pulse_width", hi inside {[60:68]}, 1);
    chk("osc_period", per inside {[120:136]}, 1);
    trimp(8'h80, p1);
    trimp(8'hc0, p2);
    trimp(8'h40, p3);
    chk("trim_order", {p1 > p0, p2 > p0, p2 < p1, p3 < p0}, 4'hf);
    wr(10'h2f2, 8'h00);
    wr(10'h2f2, 8'h80);
    wr(10'h2f2, 8'h9c);
    meas(per, hi);
    chk("min_half_period", hi, 2);
    chk("min_clock_period", per, 4);
    wr(10'h2f2, 8'h00);
    wr(10'h2f1, 8'h02);
    i_lowvolt_below <= 1'b1;
    repeat (8) @(posedge i_clk);
    rdc(10'h2f1, 8'h07);
    chk("lowvolt_irq", o_lowvolt_irq, 1);
    wr(10'h2f1, 8'h03);
    rdc(10'h2f1, 8'h06);
    chk("lowvolt_irq", o_lowvolt_irq, 0);
    i_reduced_power_mode <= 1'b1;
    repeat (8) @(posedge i_clk);
    rdc(10'h2f1, 8'h03);
    chk("lowvolt_irq", o_lowvolt_irq, 1);
    wr(10'h2f1, 8'h05);
    rdc(10'h2f1, 8'h00);
    i_rstn <= 1'b0;
    @(posedge i_clk);
    chk("waitrequest", o_waitrequest, 1);
    chk("outputs", {o_lowvolt_irq, o_wake_irq, o_wake_pin, o_wake_pin_oe}, 0);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    rdc(10'h2f3, 8'ha8);
    rdc(10'h2f1, 8'h00);
    stop_test();
  end
endmodule // pwl_top_tb
